// ===== core/sthp_fifo_if.sv
// Signals between the port logic and its transmit FIFO.
// Assumes write side on the host clock, read side on the reference clock.
`timescale 1ns/10ps
interface sthp_fifo_if;
    import sthp_pkg::*;

    // Write side, host clock domain
    logic               wr_ce;
    logic               wr_en;
    logic [ENTRY_W-1:0] wr_data;
    logic               wr_full;
    logic               wr_half;
    logic               wr_empty;
    // Read side, reference clock domain
    logic               rd_ce;
    logic               rd_en;
    logic [ENTRY_W-1:0] rd_data;
    logic               rd_empty;

    modport store (
        input  wr_ce, wr_en, wr_data, rd_ce, rd_en,
        output wr_full, wr_half, wr_empty, rd_data, rd_empty
    );
    modport user (
        output wr_ce, wr_en, wr_data, rd_ce, rd_en,
        input  wr_full, wr_half, wr_empty, rd_data, rd_empty
    );
endinterface

// ===== core/sthp_pkg.sv
// Constants, types and field decoding shared by the tx host port files.
// Assumes a 32-bit APB register bus on the reference clock.
package sthp_pkg;

    // Data path widths and FIFO geometry
    localparam int WORD_W       = 12;
    localparam int ENTRY_W      = 13;
    localparam int FIFO_AW      = 8;
    localparam int FIFO_DEPTH   = 256;
    localparam int HOST_MAX_MHZ = 50;

    // Serial character lengths in bits
    localparam logic [3:0] LEN_10 = 4'ha;
    localparam logic [3:0] LEN_12 = 4'hc;

    // Register map, byte addresses
    localparam int         ADDR_W   = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_CHAR = 8'h08;

    // Control register fields
    localparam int         CTL_W         = 7;
    localparam int         CTL_ENC_BYP_N = 0;
    localparam int         CTL_WIDTH     = 1;
    localparam int         CTL_FIFO_BYP_N = 2;
    localparam int         CTL_CONV      = 3;
    localparam int         CTL_RANGE     = 4;
    localparam int         CTL_SPEED     = 5;
    localparam int         CTL_SER_EN    = 6;
    localparam logic [6:0] CTRL_RESET    = 7'h07;

    // Status register fields
    localparam int ST_EMPTY = 0;
    localparam int ST_INVAL = 1;
    localparam int ST_MODE  = 2;
    localparam int ST_BUSY  = 4;
    localparam int ST_COUNT = 16;

    typedef enum logic [1:0] {
        SER_IDLE  = 2'b01,
        SER_SHIFT = 2'b10
    } sthp_ser_t;

    typedef struct packed {
        logic [11:0] data;
        logic        cmd;
        logic        intr;
        logic        halt_n;
        logic        svs;
        logic        soc;
    } sthp_fields_t;

    // Splits one stored entry (cmd select on top) by input format
    function automatic sthp_fields_t decode_word(
        input logic [ENTRY_W-1:0] e,
        input logic               enc_n,
        input logic               wsel,
        input logic               fifo_on
    );
        sthp_fields_t f;
        f        = '0;
        f.halt_n = 1'b1;
        case ({enc_n, wsel})
            2'b11:
            begin
                f.data = {4'h0, e[7:0]};
                f.cmd  = e[12];
                f.svs  = e[10];
                if (fifo_on)
                begin
                    f.intr   = e[8];
                    f.halt_n = e[9];
                    f.soc    = e[11];
                end
            end
            2'b01: f.data = {2'b00, e[9:0]};
            2'b10:
            begin
                f.data = {2'b00, e[9:0]};
                f.cmd  = e[12];
                f.svs  = e[10];
                f.soc  = fifo_on & e[11];
            end
            default: f.data = e[11:0];
        endcase
        return f;
    endfunction

    // Clocking mode: 0 async, 1..3 sync at x1, x2, x4 reference rate
    function automatic logic [1:0] clock_mode(
        input logic range_sel,
        input logic speed_sel,
        input logic fifo_on
    );
        if (fifo_on)
            return 2'h0;
        else if (range_sel)
            return 2'h3;
        else if (speed_sel)
            return 2'h2;
        else
            return 2'h1;
    endfunction

endpackage

// ===== core/sthp_tx_fifo.sv
// Dual-clock transmit FIFO with gray pointers and show-ahead read.
// Assumes one async active-low reset shared by both clock domains.
`timescale 1ns/10ps
module sthp_tx_fifo #(
    parameter int AW = sthp_pkg::FIFO_AW  // Address bits, depth 2**AW
)
(
    input wire logic   wclk,    // Host write clock
    input wire logic   rclk,    // Reference read clock
    input wire logic   arst_n,  // Async reset, active low
    sthp_fifo_if.store f        // FIFO signals
);
    import sthp_pkg::*;

    localparam int         DEPTH = 1 << AW;
    localparam logic [AW:0] HALF = (AW + 1)'(DEPTH / 2);

    logic [ENTRY_W-1:0] mem [0:DEPTH-1];
    logic [AW:0]        wbin;
    logic [AW:0]        wgray;
    logic [AW:0]        rq_a;
    logic [AW:0]        rq_b;
    logic [AW:0]        rbin;
    logic [AW:0]        rgray;
    logic [AW:0]        wq_a;
    logic [AW:0]        wq_b;
    logic [AW:0]        next_wbin;
    logic [AW:0]        next_rbin;
    logic [AW:0]        wlevel;
    logic               push;
    logic               pop;

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--)
            b[i] = b[i + 1] ^ g[i];
        return b;
    endfunction

    // Write side: full refuses the push and keeps contents
    always_comb
    begin
        f.wr_full  = wgray == {~rq_b[AW:AW-1], rq_b[AW-2:0]};
        push       = f.wr_ce & f.wr_en & ~f.wr_full;
        next_wbin  = push ? wbin + 1'b1 : wbin;
        wlevel     = wbin - gray2bin(rq_b);
        f.wr_half  = wlevel >= HALF;
        f.wr_empty = wgray == rq_b;
    end

    // Write pointer and read pointer synchroniser
    always_ff @(posedge wclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wbin  <= '0;
            wgray <= '0;
            rq_a  <= '0;
            rq_b  <= '0;
        end
        else if (f.wr_ce)
        begin
            wbin  <= next_wbin;
            wgray <= bin2gray(next_wbin);
            rq_a  <= rgray;
            rq_b  <= rq_a;
        end
    end

    // Storage array written on the host clock
    always_ff @(posedge wclk)
    begin
        if (push)
            mem[wbin[AW-1:0]] <= f.wr_data;
    end

    // Read side: head entry shown while not empty
    always_comb
    begin
        f.rd_empty = rgray == wq_b;
        pop        = f.rd_ce & f.rd_en & ~f.rd_empty;
        next_rbin  = pop ? rbin + 1'b1 : rbin;
        f.rd_data  = mem[rbin[AW-1:0]];
    end

    // Read pointer and write pointer synchroniser
    always_ff @(posedge rclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rbin  <= '0;
            rgray <= '0;
            wq_a  <= '0;
            wq_b  <= '0;
        end
        else if (f.rd_ce)
        begin
            rbin  <= next_rbin;
            rgray <= bin2gray(next_rbin);
            wq_a  <= wgray;
            wq_b  <= wq_a;
        end
    end

endmodule

// ===== core/sthp_tx_host_port.sv
// Transmit host input port: input register, FIFO write port, serializer.
// Assumes APB on MCLK (the reference clock) and a free host write clock.
//
// What this block does
// - Latch the 12-bit word and select on the chosen sample clock edge.
// - Bypass and width control register bits choose one of four input formats.
// - Encoded 8-bit: bits 8-11 are controls; bypassed FIFO ignores 8, 9, 11.
// - Encoded 10 adds violation, and cell start with FIFO enabled; pre-encoded 10 drops extras.
// - Pre-encoded characters leave bit 0 first, ascending, as NRZ.
// - Convention control register bit sets polarity of enable, full and empty.
// - Sync and async clocking, each with both timing models.
// - Bypassed FIFO: whole path including input register on reference clock.
// - FIFO enabled: host clock drives input register and FIFO writes.
// - Async mode reads the FIFO on the reference clock only.
// - UTOPIA: empty, full and enable are active low.
// - Address match plus enable selects; writes every cycle enable stays.
// - Cascade: active high levels, same selection sequence.
// - Cascade write enable leads its data by one clock.
// - Cascade lets an external synchronous FIFO drive the port directly.
// - Async mode has a 256-entry FIFO written up to 50 MHz.
// - FIFO full, half-full and empty flags follow the host clock.
`timescale 1ns/10ps
module sthp_tx_host_port
(
    input  wire logic                        MCLK,      // Reference clock
    input  wire logic                        ARST_N,    // Async reset
    input  wire logic                        CE,        // Clock enable
    input  wire logic                        PSEL,      // APB select
    input  wire logic                        PENABLE,   // APB enable
    input  wire logic                        PWRITE,    // APB write
    input  wire logic [sthp_pkg::ADDR_W-1:0] PADDR,     // APB address
    input  wire logic [31:0]                 PWDATA,    // APB write data
    output      logic [31:0]                 PRDATA,    // APB read data
    output      logic                        PREADY,    // APB ready
    output      logic                        PSLVERR,   // APB error
    input  wire logic                        HOST_WRITE_CLOCK,  // Host clk
    input  wire logic [sthp_pkg::WORD_W-1:0] TX_HOST_WORD,      // Word
    input  wire logic                        TX_CMD_OR_DATA_SEL, // Select
    input  wire logic                        TX_WRITE_ENABLE,   // Enable
    input  wire logic                        ADDRESS_MATCH_IN_N, // Addr
    output      logic                        TX_FIFO_EMPTY_FLAG, // Empty
    output      logic                        TX_FIFO_FULL_FLAG,  // Full
    output      logic                        TX_FIFO_HALF_FLAG,  // Half
    output      logic                        TX_SERIAL_DATA,    // NRZ out
    output      logic                        CHAR_VALID,  // Char taken
    output      logic [sthp_pkg::WORD_W-1:0] CHAR_DATA,   // Char data
    output      logic                        CHAR_CMD,    // Command
    output      logic                        CHAR_INT,    // Interrupt
    output      logic                        CHAR_HALT_N, // Halt
    output      logic                        CHAR_SVS,    // Violation
    output      logic                        CHAR_SOC     // Cell start
);
    import sthp_pkg::*;

    sthp_fifo_if fifo_bus ();

    // Control register and derived settings
    logic [CTL_W-1:0]   ctrl;
    logic [CTL_W-1:0]   next_ctrl;
    logic               fifo_on;
    logic               cascade;
    logic               enc_n;
    logic               wsel;
    logic [1:0]         mode;

    // Host clock domain
    logic [2:0]         h_cfg_a;
    logic [2:0]         h_cfg_b;
    logic               h_ce;
    logic               h_casc;
    logic               h_fifo;
    logic               h_en_act;
    logic               h_qual;
    logic               h_cap;
    logic               h_sel;
    logic               h_pend;
    logic               h_push;
    logic [ENTRY_W-1:0] h_in;
    logic [2:0]         h_flag;
    logic               next_h_sel;
    logic               next_h_pend;
    logic               next_h_push;
    logic [ENTRY_W-1:0] next_h_in;
    logic [2:0]         next_h_flag;

    // Reference domain input register for bypassed FIFO
    logic [14:0]        r_pin_a;
    logic [14:0]        r_pin_b;
    logic               r_en_act;
    logic               r_qual;
    logic               r_cap;
    logic               r_sel;
    logic               r_pend;
    logic [ENTRY_W-1:0] r_in;
    logic               r_in_valid;
    logic               next_r_sel;
    logic               next_r_pend;
    logic [ENTRY_W-1:0] next_r_in;
    logic               next_r_in_valid;

    // Character taker and serializer
    sthp_ser_t          ser_state;
    sthp_ser_t          next_ser_state;
    logic [3:0]         ser_cnt;
    logic [3:0]         next_ser_cnt;
    logic [WORD_W-1:0]  ser_shift;
    logic [WORD_W-1:0]  next_ser_shift;
    logic               ser_out;
    logic               next_ser_out;
    logic               take;
    logic [ENTRY_W-1:0] src;
    sthp_fields_t       fld;
    sthp_fields_t       char_q;
    sthp_fields_t       next_char_q;
    logic               char_vld;
    logic               next_char_vld;
    logic [15:0]        char_cnt;
    logic [15:0]        next_char_cnt;
    logic [31:0]        next_prdata;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a == REG_CTRL || a == REG_STAT || a == REG_CHAR;
    endfunction

    // Settings taken from the control register
    always_comb
    begin
        fifo_on = ctrl[CTL_FIFO_BYP_N];
        cascade = ctrl[CTL_CONV];
        enc_n   = ctrl[CTL_ENC_BYP_N];
        wsel    = ctrl[CTL_WIDTH];
        mode    = clock_mode(ctrl[CTL_RANGE], ctrl[CTL_SPEED],
                             fifo_on);
    end

    // Settings carried into the host clock domain
    always_ff @(posedge HOST_WRITE_CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            h_cfg_a <= 3'h0;
            h_cfg_b <= 3'h0;
        end
        else
        begin
            h_cfg_a <= {CE, cascade, fifo_on};
            h_cfg_b <= h_cfg_a;
        end
    end

    assign h_ce   = h_cfg_b[2];
    assign h_casc = h_cfg_b[1];
    assign h_fifo = h_cfg_b[0];

    // Host side selection, input register and FIFO push
    always_comb
    begin
        h_en_act    = TX_WRITE_ENABLE ^ ~h_casc;
        h_qual      = h_en_act & (~ADDRESS_MATCH_IN_N | h_sel);
        next_h_sel  = h_qual;
        next_h_pend = h_qual & h_casc;
        h_cap       = h_casc ? h_pend : h_qual;
        next_h_in   = h_cap ? {TX_CMD_OR_DATA_SEL, TX_HOST_WORD}
                            : h_in;
        next_h_push = h_cap & h_fifo;
        next_h_flag = {fifo_bus.wr_half, fifo_bus.wr_full,
                       fifo_bus.wr_empty} ^ {3{~h_casc}};
        fifo_bus.wr_ce   = h_ce;
        fifo_bus.wr_en   = h_push;
        fifo_bus.wr_data = h_in;
    end

    always_ff @(posedge HOST_WRITE_CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            h_sel  <= 1'b0;
            h_pend <= 1'b0;
            h_push <= 1'b0;
            h_in   <= '0;
            h_flag <= 3'h0;
        end
        else if (h_ce)
        begin
            h_sel  <= next_h_sel;
            h_pend <= next_h_pend;
            h_push <= next_h_push;
            h_in   <= next_h_in;
            h_flag <= next_h_flag;
        end
    end

    assign TX_FIFO_EMPTY_FLAG = h_flag[0];
    assign TX_FIFO_FULL_FLAG  = h_flag[1];
    assign TX_FIFO_HALF_FLAG  = h_flag[2];

    // Transmit FIFO, host writes and reference reads
    sthp_tx_fifo #(
        .AW     (FIFO_AW)
    ) u_fifo (
        .wclk   (HOST_WRITE_CLOCK),
        .rclk   (MCLK),
        .arst_n (ARST_N),
        .f      (fifo_bus)
    );

    // Host pins resampled on the reference clock
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            r_pin_a <= 15'h0000;
            r_pin_b <= 15'h0000;
        end
        else if (CE)
        begin
            r_pin_a <= {ADDRESS_MATCH_IN_N, TX_WRITE_ENABLE,
                        TX_CMD_OR_DATA_SEL, TX_HOST_WORD};
            r_pin_b <= r_pin_a;
        end
    end

    // Reference clocked input register when the FIFO is bypassed
    always_comb
    begin
        r_en_act    = r_pin_b[13] ^ ~cascade;
        r_qual      = r_en_act & (~r_pin_b[14] | r_sel);
        next_r_sel  = r_qual;
        next_r_pend = r_qual & cascade;
        r_cap       = (cascade ? r_pend : r_qual) & ~fifo_on;
        next_r_in   = r_cap ? r_pin_b[12:0] : r_in;
        // New capture wins over the take; a late word overwrites
        next_r_in_valid = r_cap | (r_in_valid & ~take);
    end

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            r_sel      <= 1'b0;
            r_pend     <= 1'b0;
            r_in       <= '0;
            r_in_valid <= 1'b0;
        end
        else if (CE)
        begin
            r_sel      <= next_r_sel;
            r_pend     <= next_r_pend;
            r_in       <= next_r_in;
            r_in_valid <= next_r_in_valid;
        end
    end

    // Takes a character and shifts pre-encoded ones out
    always_comb
    begin
        take = (ser_state == SER_IDLE) & ctrl[CTL_SER_EN]
             & (fifo_on ? ~fifo_bus.rd_empty : r_in_valid);
        src  = fifo_on ? fifo_bus.rd_data : r_in;
        fld  = decode_word(src, enc_n, wsel, fifo_on);
        fifo_bus.rd_ce = CE;
        fifo_bus.rd_en = take & fifo_on;
        next_ser_state = ser_state;
        next_ser_cnt   = ser_cnt;
        next_ser_shift = ser_shift;
        next_ser_out   = 1'b0;
        next_char_q    = char_q;
        next_char_vld  = 1'b0;
        next_char_cnt  = char_cnt;
        case (ser_state)
            SER_IDLE:
            begin
                if (take)
                begin
                    next_char_q    = fld;
                    next_char_vld  = 1'b1;
                    next_char_cnt  = char_cnt + 16'h0001;
                    next_ser_shift = enc_n ? '0 : fld.data;
                    next_ser_cnt   = (!enc_n && !wsel) ? LEN_12 - 4'h1
                                                       : LEN_10 - 4'h1;
                    next_ser_state = SER_SHIFT;
                end
            end
            SER_SHIFT:
            begin
                next_ser_out   = ser_shift[0];
                next_ser_shift = ser_shift >> 1;
                next_ser_cnt   = ser_cnt - 4'h1;
                if (ser_cnt == 4'h0)
                    next_ser_state = SER_IDLE;
            end
            default: next_ser_state = SER_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ser_state <= SER_IDLE;
            ser_cnt   <= 4'h0;
            ser_shift <= '0;
            ser_out   <= 1'b0;
            char_q    <= '{default: 1'b0, halt_n: 1'b1};
            char_vld  <= 1'b0;
            char_cnt  <= 16'h0000;
        end
        else if (CE)
        begin
            ser_state <= next_ser_state;
            ser_cnt   <= next_ser_cnt;
            ser_shift <= next_ser_shift;
            ser_out   <= next_ser_out;
            char_q    <= next_char_q;
            char_vld  <= next_char_vld;
            char_cnt  <= next_char_cnt;
        end
    end

    assign TX_SERIAL_DATA = ser_out;
    assign CHAR_VALID     = char_vld;
    assign CHAR_DATA      = char_q.data;
    assign CHAR_CMD       = char_q.cmd;
    assign CHAR_INT       = char_q.intr;
    assign CHAR_HALT_N    = char_q.halt_n;
    assign CHAR_SVS       = char_q.svs;
    assign CHAR_SOC       = char_q.soc;

    // APB: zero wait, write at access, read data caught at setup
    always_comb
    begin
        next_ctrl   = ctrl;
        next_prdata = PRDATA;
        if (PSEL && PENABLE && PWRITE && PADDR == REG_CTRL)
            next_ctrl = PWDATA[CTL_W-1:0];
        if (PSEL && !PENABLE && !PWRITE)
        begin
            case (PADDR)
                REG_CTRL: next_prdata = {25'h0000000, ctrl};
                REG_STAT:
                begin
                    next_prdata                   = 32'h00000000;
                    next_prdata[ST_EMPTY]         = fifo_bus.rd_empty;
                    next_prdata[ST_INVAL]         = r_in_valid;
                    next_prdata[ST_MODE+1:ST_MODE] = mode;
                    next_prdata[ST_BUSY]          = ser_state == SER_SHIFT;
                    next_prdata[ST_COUNT+15:ST_COUNT] = char_cnt;
                end
                REG_CHAR: next_prdata = {15'h0000, char_q};
                default:  next_prdata = 32'h00000000;
            endcase
        end
        PREADY  = 1'b1;
        PSLVERR = PSEL & PENABLE & ~is_mapped(PADDR);
    end

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ctrl   <= CTRL_RESET;
            PRDATA <= 32'h00000000;
        end
        else if (CE)
        begin
            ctrl   <= next_ctrl;
            PRDATA <= next_prdata;
        end
    end

endmodule

// ===== dv/sthp_host_model.sv
// Host word source, UTOPIA or Cascade timing, four words a burst.
// Assumes go is high for one host clock to start a burst.
`timescale 1ns/10ps
module sthp_host_model
(
    input  wire logic        hclk,  // Host clock
    input  wire logic        casc,  // Cascade timing
    input  wire logic        go,    // Start
    input  wire logic [47:0] words, // Words, first low
    output logic [11:0]      word,  // Word bus
    output logic             en,    // Write enable
    output logic             am_n   // Address match
);
    int i = 9;
    int k;
    // Burst step counter, one word per host clock
    always @(posedge hclk)
        i <= go ? 0 : (i < 9 ? i + 1 : 9);
    // Levels per convention; data lags enable in Cascade
    assign k = casc ? i - 1 : i;
    assign en = casc ~^ (i < 4);
    assign am_n = (i != 0);
    assign word = (k >= 0 && k < 4) ? words[k*12 +: 12]
                : {12{i[0]}} ^ 12'h5a5;
endmodule

// ===== dv/sthp_port_sva.sv
// Port checker: APB answers and character take timing.
// Assumes binding into sthp_tx_host_port, seeing only its ports.
`timescale 1ns/10ps
module sthp_port_sva
(
    input wire logic        MCLK,       // Ref clock
    input wire logic        ARST_N,     // Reset
    input wire logic        PSEL,       // Select
    input wire logic        PENABLE,    // Enable
    input wire logic        PWRITE,     // Write
    input wire logic [7:0]  PADDR,      // Address
    input wire logic [31:0] PRDATA,     // Read data
    input wire logic        PREADY,     // Ready
    input wire logic        PSLVERR,    // Error
    input wire logic        CHAR_VALID, // Char taken
    input wire logic [11:0] CHAR_DATA   // Char data
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    // Access phase and one complete take
    sequence s_acc; PSEL && PENABLE; endsequence
    sequence s_take; CHAR_VALID ##1 !CHAR_VALID; endsequence
    // Bus answer properties
    property p_rdy; PREADY; endproperty
    property p_err_acc; PSLVERR |-> PSEL && PENABLE; endproperty
    property p_err_map;
        s_acc |-> PSLVERR == !(PADDR inside {8'h00, 8'h04, 8'h08});
    endproperty
    property p_err_drop; PSLVERR |=> !PSLVERR; endproperty
    property p_rdata;
        !(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA);
    endproperty
    // Take pulse, spacing and held fields
    property p_pulse; CHAR_VALID |=> !CHAR_VALID; endproperty
    property p_space; s_take |=> !CHAR_VALID [*8]; endproperty
    property p_hold; CHAR_VALID |=> $stable(CHAR_DATA) [*8]; endproperty
    a_rdy: assert property (p_rdy)
        else $error("ready low");
    a_err_acc: assert property (p_err_acc)
        else $error("error outside access");
    a_err_map: assert property (p_err_map)
        else $error("error wrong for address");
    a_err_drop: assert property (p_err_drop)
        else $error("error held too long");
    a_rdata: assert property (p_rdata)
        else $error("read data moved");
    a_pulse: assert property (p_pulse)
        else $error("take pulse too long");
    a_space: assert property (p_space)
        else $error("takes too close");
    a_hold: assert property (p_hold)
        else $error("char data moved");
endmodule
bind sthp_tx_host_port sthp_port_sva chk_u (.MCLK, .ARST_N, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .CHAR_VALID,
    .CHAR_DATA);

// ===== dv/sthp_tx_host_port_bench.sv
// Bench: four formats under both timing models, plus APB checks.
// Assumes the host model and the bound port checker.
`timescale 1ns/10ps
module sthp_tx_host_port_bench;
    import sthp_pkg::*;
    logic mclk = 0, hclk = 0, arst_n = 0, psel = 0, pen = 0, pwr = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, cmd = 0, go = 0, en, am_n, empty, full;
    logic cv, ccmd, sdo, half, cint, chalt, csvs, csoc;
    logic [11:0] word, cdata, s;
    logic [47:0] words = 0;
    logic [20:0] e, expq[$];
    int fail_count = 0, total_checks = 0, seed = 74862;
    // Clocks, unrelated phases
    always #2 mclk = ~mclk;
    initial #1.3 forever #16 hclk = ~hclk;
    sthp_tx_host_port dut_u (.MCLK(mclk), .ARST_N(arst_n), .CE(1'b1),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .HOST_WRITE_CLOCK(hclk), .TX_HOST_WORD(word),
        .TX_CMD_OR_DATA_SEL(cmd), .TX_WRITE_ENABLE(en),
        .ADDRESS_MATCH_IN_N(am_n), .TX_FIFO_EMPTY_FLAG(empty),
        .TX_FIFO_FULL_FLAG(full), .TX_FIFO_HALF_FLAG(half),
        .TX_SERIAL_DATA(sdo), .CHAR_VALID(cv), .CHAR_DATA(cdata),
        .CHAR_CMD(ccmd), .CHAR_INT(cint), .CHAR_HALT_N(chalt),
        .CHAR_SVS(csvs), .CHAR_SOC(csoc));
    sthp_host_model host_u (.hclk(hclk), .casc(pwdata[3]), .go(go),
        .words(words), .word(word), .en(en), .am_n(am_n));
    task chk(input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (x !== g)
        begin
            fail_count++;
            $display("Error at %0t exp %h got %h", $time, x, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        pen <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, pen} <= 2'b00;
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Expected: {soc, svs, halt_n, int, serial bits, cmd, data}
    // Format f is {width select, encoder bypass}
    function logic [20:0] exp_of(logic [11:0] w, logic [1:0] f, logic c);
        case (f)
            2'b11: return {w[11:8], 4'd0, c, 4'h0, w[7:0]};
            2'b10: return {4'h2, 4'd10, 1'b0, 2'b0, w[9:0]};
            2'b01: return {w[11:10], 2'b10, 4'd0, c, 2'b0, w[9:0]};
            default: return {4'h2, 4'd12, 1'b0, w};
        endcase
    endfunction
    // Take monitor: oldest note against taken char and its bits
    initial
    forever
    begin
        @(negedge mclk);
        if (cv === 1'b1)
        begin
            e = expq.size() ? expq.pop_front() : '1;
            chk(e[11:0], cdata);
            chk(e[12], ccmd);
            chk(e[20:17], {csoc, csvs, chalt, cint});
            s = 0;
            for (int b = 0; b < e[16:13]; b++)
            begin
                @(negedge mclk);
                s[b] = sdo;
            end
            if (e[16:13] != 0) chk(e[11:0], s);
        end
    end
    // Main sequence
    initial
    begin
        repeat (8) @(posedge hclk);
        arst_n <= 1;
        apb(0, REG_CTRL, 0);
        chk({25'h0, CTRL_RESET}, rd);
        apb(0, 8'h0c, 0);
        chk(32'h0, rd);
        chk(32'h1, er);
        apb(1, REG_CTRL, 32'h10);
        apb(0, REG_STAT, 0);
        chk(rd[3:2], 3);
        for (int m = 0; m < 8; m++)
        begin
            apb(1, REG_CTRL, 32'h44 + m[1:0] + 8 * m[2]);
            repeat (6) @(posedge hclk);
            cmd <= 1'($random(seed));
            words <= 48'({$random(seed), $random(seed)});
            go <= 1;
            @(posedge hclk);
            go <= 0;
            for (int k = 0; k < 4; k++)
                expq.push_back(exp_of(words[k*12 +: 12], m[1:0], cmd));
            while (expq.size() > 0) @(posedge mclk);
            repeat (8) @(posedge hclk);
            chk(empty, m[2]);
            chk(full, !m[2]);
            chk(half, !m[2]);
            $display("test %0d done", m);
        end
        stop_test;
    end
    // Watchdog
    initial
    begin
        #100000;
        fail_count++;
        stop_test;
    end
endmodule
